/* File: hw/burst_sram_port.sv */
// Synchronous host port of a pipelined burst SRAM with its storage array.
// Assumes controller logic on i_clk_sys drives every input.
// Operation
// - A high step input holds the burst counter so the write word stays.
// - Bursts advance only the two low address bits, order set by strap.
// - Captured inputs need not survive sleep; a new strobe is needed.
// - Selected only with primary and low select low and high select high.
// - Reads start the same from either address strobe.
// - Byte gate with all lane selects writes like the global write.
// - Strap high gives interleaved order, start XOR one, two, three.
// - Strap low gives linear order, start plus count modulo four.
// - After the fourth word the counter wraps to the start bits.
`timescale 1ns/1ps
module burst_sram_port #(
    parameter int DEPTH = 1 << burst_sram_pkg::ADDR_W
) (
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic [burst_sram_pkg::ADDR_W-1:0] i_addr,
    input wire logic i_chip_enable_n,
    input wire logic i_select_high,
    input wire logic i_select_low_n,
    input wire logic i_proc_addr_strobe_n,
    input wire logic i_ctrl_addr_strobe_n,
    input wire logic i_burst_step_n,
    input wire logic i_burst_order_select,
    input wire logic i_global_write_n,
    input wire logic i_byte_write_gate_n,
    input wire logic [burst_sram_pkg::LANES-1:0] i_byte_lane_write_n,
    input wire logic i_sleep_request,
    input wire logic [burst_sram_pkg::DATA_W-1:0] i_wdata,
    output logic [burst_sram_pkg::DATA_W-1:0] o_rdata,
    output logic o_rvalid,
    output logic [burst_sram_pkg::ADDR_W-1:0] o_cur_addr
);
    import burst_sram_pkg::*;

    // ----------------------------------------------------------------
    // Decode
    // ----------------------------------------------------------------
    function automatic logic [LANES-1:0] lane_enables(
        input logic gw_n,
        input logic gate_n,
        input logic [LANES-1:0] lanes_n
    );
        logic [LANES-1:0] en;
        en = {LANES{1'b0}};
        if (!gw_n) begin
            en = {LANES{1'b1}};
        end else if (!gate_n) begin
            en = ~lanes_n;
        end
        return en;
    endfunction : lane_enables

    logic selected;
    logic proc_start;
    logic ctrl_start;
    logic start;
    logic [LANES-1:0] lane_we;
    assign selected = !i_chip_enable_n && !i_select_low_n && i_select_high;
    // Processor strobe starts reads only; the write decision comes later
    assign proc_start = !i_proc_addr_strobe_n && selected;
    assign ctrl_start = !i_ctrl_addr_strobe_n && selected;
    assign start = (proc_start || ctrl_start) && !i_sleep_request;
    assign lane_we = lane_enables(i_global_write_n, i_byte_write_gate_n,
        i_byte_lane_write_n);

    // ----------------------------------------------------------------
    // Address capture and burst counter
    // ----------------------------------------------------------------
    logic [ADDR_W-1:0] base_reg;
    logic [1:0] count_reg;
    access_t state_reg;
    logic [1:0] low_bits;
    logic [ADDR_W-1:0] cur_addr;

    always_ff @(posedge i_clk_sys) begin
        if (i_rst || i_sleep_request) begin
            // Sleep drops captured inputs; a fresh strobe is required
            state_reg <= ST_IDLE;
            base_reg <= ADDR_RESET;
            count_reg <= BURST_ZERO;
        end else if (start) begin
            base_reg <= i_addr;
            count_reg <= BURST_ZERO;
            state_reg <= ST_READ;
        end else if (!selected && !i_ctrl_addr_strobe_n) begin
            state_reg <= ST_IDLE;
        end else if (state_reg != ST_IDLE) begin
            if (!i_burst_step_n) begin
                count_reg <= count_reg + BURST_ONE;
            end
            // Step high holds the counter so a write word repeats
            if (i_proc_addr_strobe_n && lane_we != {LANES{1'b0}}) begin
                state_reg <= ST_WRITE;
            end else begin
                state_reg <= ST_READ;
            end
        end
    end

    burst_addr_gen u_gen (
        .i_start(base_reg[1:0]),
        .i_count(count_reg),
        .i_burst_order_select(i_burst_order_select),
        .o_low(low_bits)
    );
    assign cur_addr = {base_reg[ADDR_W-1:2], low_bits};
    assign o_cur_addr = cur_addr;

    // ----------------------------------------------------------------
    // Storage and pipelined read
    // ----------------------------------------------------------------
    wire logic [DATA_W-1:0] rd_word;
    logic write_now;
    assign write_now = state_reg != ST_IDLE && !start && i_proc_addr_strobe_n
        && !i_sleep_request;

    genvar g;
    generate
        for (g = 0; g < LANES; g++) begin : g_lane
            // One array per lane, so no two processes write one array
            logic [LANE_W-1:0] lane_mem [DEPTH];
            always_ff @(posedge i_clk_sys) begin
                if (write_now && lane_we[g]) begin
                    lane_mem[cur_addr] <=
                        i_wdata[g*LANE_W +: LANE_W];
                end
            end
            assign rd_word[g*LANE_W +: LANE_W] = lane_mem[cur_addr];
        end
    endgenerate

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            o_rdata <= DATA_RESET;
            o_rvalid <= 1'b0;
        end else begin
            // Output register gives one cycle of pipeline latency
            o_rdata <= rd_word;
            o_rvalid <= state_reg != ST_IDLE && !i_sleep_request
                && !(write_now && lane_we != {LANES{1'b0}});
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    property p_hold;
        @(posedge i_clk_sys) disable iff (i_rst)
        (state_reg != ST_IDLE && !start && i_burst_step_n && selected
         && !i_sleep_request) |=> $stable(count_reg);
    endproperty
    a_hold: assert property (p_hold) else $error("count moved on hold");

    property p_step;
        @(posedge i_clk_sys) disable iff (i_rst)
        (state_reg != ST_IDLE && !start && !i_burst_step_n && selected
         && !i_sleep_request) |=> count_reg == $past(count_reg) + 2'h1;
    endproperty
    a_step: assert property (p_step) else $error("count did not step");

    property p_upper;
        @(posedge i_clk_sys) disable iff (i_rst)
        !start && !i_sleep_request |=> $stable(cur_addr[ADDR_W-1:2]);
    endproperty
    a_upper: assert property (p_upper) else $error("upper bits moved");

    property p_inter;
        @(posedge i_clk_sys) disable iff (i_rst)
        i_burst_order_select |-> low_bits == (base_reg[1:0] ^ count_reg);
    endproperty
    a_inter: assert property (p_inter) else $error("bad interleave");

    property p_linear;
        @(posedge i_clk_sys) disable iff (i_rst)
        !i_burst_order_select |->
            low_bits == 2'(base_reg[1:0] + count_reg);
    endproperty
    a_linear: assert property (p_linear) else $error("bad linear");

    property p_wrap;
        @(posedge i_clk_sys) disable iff (i_rst)
        start ##1 (!start && !i_burst_step_n && !i_sleep_request
            && selected)[*4] |=> low_bits == $past(base_reg[1:0], 4);
    endproperty
    a_wrap: assert property (p_wrap) else $error("no wrap");

    property p_sel;
        @(posedge i_clk_sys) disable iff (i_rst)
        (!i_proc_addr_strobe_n && !i_sleep_request && !selected
         && i_ctrl_addr_strobe_n && state_reg == ST_IDLE)
        |=> state_reg == ST_IDLE;
    endproperty
    a_sel: assert property (p_sel) else $error("start while deselected");

    property p_same;
        @(posedge i_clk_sys) disable iff (i_rst)
        start |=> base_reg == $past(i_addr) && count_reg == 2'h0;
    endproperty
    a_same: assert property (p_same) else $error("bad capture");

    property p_sleep;
        @(posedge i_clk_sys) disable iff (i_rst)
        i_sleep_request |=> state_reg == ST_IDLE && !o_rvalid;
    endproperty
    a_sleep: assert property (p_sleep) else $error("state kept in sleep");

    property p_pipe;
        @(posedge i_clk_sys) disable iff (i_rst)
        ##1 o_rvalid |-> o_rdata == $past(rd_word);
    endproperty
    a_pipe: assert property (p_pipe) else $error("read latency wrong");

    c_burst: cover property (@(posedge i_clk_sys)
        start ##1 (!i_burst_step_n)[*3]);
    c_write: cover property (@(posedge i_clk_sys) write_now && lane_we != 4'h0);
    c_suspend: cover property (@(posedge i_clk_sys)
        write_now && i_burst_step_n);
endmodule : burst_sram_port

/* File: hw/burst_sram_pkg.sv */
// Constants shared by the pipelined burst SRAM port.
// Assumes a single rising-edge clock and synchronous active-high reset.
package burst_sram_pkg;
    localparam int ADDR_W = 10;
    localparam int LANES = 4;
    localparam int LANE_W = 9;
    localparam int DATA_W = LANES * LANE_W;
    localparam logic [1:0] BURST_ZERO = 2'h0;
    localparam logic [1:0] BURST_ONE = 2'h1;
    localparam logic [1:0] BURST_LAST = 2'h3;
    localparam logic [ADDR_W-1:0] ADDR_RESET = 10'h000;
    localparam logic [DATA_W-1:0] DATA_RESET = 36'h0;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_READ = 2'b01,
        ST_WRITE = 2'b11
    } access_t;
endpackage : burst_sram_pkg

/* File: hw/burst_addr_gen.sv */
// Burst address generator for the two low address bits.
// Assumes the start bits and the step count come from the same clock.
`timescale 1ns/1ps
module burst_addr_gen (
    input wire logic [1:0] i_start,
    input wire logic [1:0] i_count,
    input wire logic i_burst_order_select,
    output logic [1:0] o_low
);
    import burst_sram_pkg::*;
    always_comb begin
        if (i_burst_order_select) begin
            o_low = i_start ^ i_count;
        end else begin
            o_low = i_start + i_count;
        end
    end
endmodule : burst_addr_gen

/* File: tb/ctrl_model.sv */
// Controller model driving the host side of the burst SRAM port.
// Assumes one caller process and the port's clock on i_clk_sys.
`timescale 1ns/1ps
module ctrl_model (
    input wire logic i_clk_sys,
    output logic [burst_sram_pkg::ADDR_W-1:0] o_addr,
    output logic [2:0] o_sel,
    output logic o_proc_addr_strobe_n,
    output logic o_ctrl_addr_strobe_n,
    output logic o_burst_step_n,
    output logic o_burst_order_select,
    output logic o_global_write_n,
    output logic o_byte_write_gate_n,
    output logic [burst_sram_pkg::LANES-1:0] o_byte_lane_write_n,
    output logic o_sleep_request,
    output logic [burst_sram_pkg::DATA_W-1:0] o_wdata
);
    import burst_sram_pkg::*;
    initial begin
        o_sel = 3'h6;
        {o_proc_addr_strobe_n, o_ctrl_addr_strobe_n, o_burst_step_n} = 3'h7;
        {o_global_write_n, o_byte_write_gate_n} = 2'h3;
        o_byte_lane_write_n = 4'hf;
        o_sleep_request = 1'b0;
        o_burst_order_select = 1'b0;
        o_addr = ADDR_RESET;
        o_wdata = DATA_RESET;
    end
    // Strap only touched while reset holds
    task automatic strap(input logic v);
        o_burst_order_select <= v;
    endtask : strap
    task automatic drive(input logic [2:0] s, input logic ps, cs, st, gw,
        gt, input logic [LANES-1:0] ln, input logic sl,
        input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge i_clk_sys);
        o_sel <= s;
        o_proc_addr_strobe_n <= ps;
        o_ctrl_addr_strobe_n <= cs;
        o_burst_step_n <= st;
        o_global_write_n <= gw;
        o_byte_write_gate_n <= gt;
        o_byte_lane_write_n <= ln;
        o_sleep_request <= sl;
        // Unused lines wander so stale values never look valid
        o_addr <= (ps & cs) ? ~o_addr : a;
        o_wdata <= (gw & gt) ? ~o_wdata : d;
    endtask : drive
endmodule : ctrl_model

/* File: tb/tb.sv */
// Self-checking bench for the burst SRAM port.
// Assumes the controller model of ctrl_model.sv.
`timescale 1ns/1ps
`define CHK(n, e, g) begin num_checks++; if ((e) !== (g)) begin \
    $display("wrong value %s exp %h got %h", n, e, g); \
    fail_count++; end end
module tb;
    import burst_sram_pkg::*;
    logic i_clk_sys = 1'b0;
    logic i_rst = 1'b1;
    logic [ADDR_W-1:0] addr, o_cur_addr;
    logic [2:0] sel;
    logic ps_n, cs_n, step_n, order, gw_n, gate_n, sleep, o_rvalid;
    logic [LANES-1:0] lanes_n;
    logic [DATA_W-1:0] wdata, o_rdata;
    logic [DATA_W-1:0] exp_mem [2**ADDR_W];
    int fail_count = 0;
    int num_checks = 0;
    int mode = 0;
    always #12.5 i_clk_sys = ~i_clk_sys;
    burst_sram_port u_burst_sram_port (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
        .i_addr(addr), .i_chip_enable_n(sel[2]), .i_select_high(sel[0]),
        .i_select_low_n(sel[1]), .i_proc_addr_strobe_n(ps_n),
        .i_ctrl_addr_strobe_n(cs_n), .i_burst_step_n(step_n),
        .i_burst_order_select(order), .i_global_write_n(gw_n),
        .i_byte_write_gate_n(gate_n), .i_byte_lane_write_n(lanes_n),
        .i_sleep_request(sleep), .i_wdata(wdata), .o_rdata(o_rdata),
        .o_rvalid(o_rvalid), .o_cur_addr(o_cur_addr));
    ctrl_model u_ctrl_model (.i_clk_sys(i_clk_sys), .o_addr(addr),
        .o_sel(sel), .o_proc_addr_strobe_n(ps_n),
        .o_ctrl_addr_strobe_n(cs_n), .o_burst_step_n(step_n),
        .o_burst_order_select(order), .o_global_write_n(gw_n),
        .o_byte_write_gate_n(gate_n), .o_byte_lane_write_n(lanes_n),
        .o_sleep_request(sleep), .o_wdata(wdata));
    // Expected burst address, only the low two bits move
    function automatic logic [ADDR_W-1:0] at(input logic [ADDR_W-1:0] b,
                                            input int k);
        logic [1:0] c;
        c = 2'(k % 4);
        return {b[ADDR_W-1:2], mode ? b[1:0] ^ c : b[1:0] + c};
    endfunction : at
    // Expected word after a write with the given lane enables
    function automatic logic [DATA_W-1:0] merge(
        input logic [DATA_W-1:0] old_w,
        input logic [DATA_W-1:0] new_w,
        input logic [LANES-1:0] en);
        logic [DATA_W-1:0] w;
        w = old_w;
        for (int g = 0; g < LANES; g++)
            if (en[g]) w[g*LANE_W +: LANE_W] = new_w[g*LANE_W +: LANE_W];
        return w;
    endfunction : merge
    task automatic go(input logic [ADDR_W-1:0] a, input logic p,
                      input logic [2:0] s);
        u_ctrl_model.drive(s, !p, p, 1'b1, 1'b1, 1'b1, 4'hf, 1'b0, a, '0);
    endtask : go
    task automatic beat(input logic st, gw, gt,
                        input logic [LANES-1:0] ln, input logic sl,
                        input logic [DATA_W-1:0] d);
        u_ctrl_model.drive(3'h1, 1'b1, 1'b1, st, gw, gt, ln, sl, '0, d);
    endtask : beat
    task automatic test_done();
        if (fail_count == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : test_done
    // ----------------------------------------
    // Main sequence, once per burst order
    // ----------------------------------------
    initial begin
        logic [ADDR_W-1:0] a, r;
        logic [DATA_W-1:0] d;
        logic [LANES-1:0] m, en;
        logic gw;
        void'($urandom(32'h3155772d));
        for (int o = 0; o < 2; o++) begin
            mode = o;
            if (o > 0) @(posedge i_clk_sys);
            i_rst <= 1'b1;
            repeat (6) @(posedge i_clk_sys);
            u_ctrl_model.strap(o[0]);
            i_rst <= 1'b0;
            @(negedge i_clk_sys);
            `CHK("rvalid", 1'b0, o_rvalid)
            `CHK("rdata", DATA_RESET, o_rdata)
            `CHK("cur_addr", ADDR_RESET, o_cur_addr)
            for (int n = 0; n < 30; n++) begin
                a = ADDR_W'($urandom);
                gw = n[0];
                // Lane mask random; global write must ignore it
                m = LANES'($urandom);
                if (gw && !n[1]) m = '0;
                en = gw ? ~m : {LANES{1'b1}};
                go(a, 1'b0, 3'h1);
                for (int k = 0; k < 4; k++) begin
                    d = DATA_W'({$urandom, $urandom});
                    exp_mem[at(a, k)] = merge(exp_mem[at(a, k)], d, en);
                    if (k == 1) beat(1'b1, gw, !gw, m, 1'b0, d);
                    beat(1'b0, gw, !gw, m, 1'b0, d);
                end
                r = {a[ADDR_W-1:2], 2'($urandom)};
                go(r, n[1], 3'h1);
                for (int k = 0; k < 5; k++) begin
                    beat(1'b0, 1'b1, 1'b1, '0, 1'b0, '0);
                    @(negedge i_clk_sys);
                    `CHK("cur_addr", at(r, k), o_cur_addr)
                    if (k > 0) begin
                        d = exp_mem[at(r, k - 1)];
                        `CHK("rdata", d, o_rdata)
                        `CHK("rvalid", 1'b1, o_rvalid)
                    end
                end
            end
            // Every select pattern, then a sleep in mid-burst
            for (int s = 0; s < 9; s++) begin
                go(a, 1'b0, (s == 8) ? 3'h1 : s[2:0]);
                beat(1'b0, 1'b1, 1'b1, '0, s == 8, '0);
                repeat (2) beat(1'b0, 1'b1, 1'b1, '0, 1'b0, '0);
                @(negedge i_clk_sys);
                `CHK("rvalid", 1'(s == 1), o_rvalid)
            end
            // Processor strobe while deselected must not start
            go(a, 1'b1, 3'h2);
            repeat (2) beat(1'b0, 1'b1, 1'b1, '0, 1'b0, '0);
            @(negedge i_clk_sys);
            `CHK("rvalid", 1'b0, o_rvalid)
        end
        test_done();
    end
    // Run needs about 810 cycles; this allows about ten times that
    initial begin
        #200000;
        fail_count++;
        test_done();
    end
endmodule : tb
